// ### rfpc_top.v
// RF port configuration and switched bias control, with the secondary control register
`timescale 1ns/1ps
`include "rfpc_regs.vh"
// Behaviour
// - Bit 12 selects port use: 0 dual-port (reset), 1 single-port.
// - Single-port mode uses the shared RF pad pair for both receive and transmit.
// - Single-port receive closes receive switch and keeps transmit amplifier off.
// - Single-port transmit opens receive switch and enables transmit amplifier.
// - Single-port, enabled bias output is high in transmit, low in receive.
// - Dual-port: input pads receive only, switch closed, their amplifier off.
// - Dual-port: separate output pads transmit, their amplifier on while transmitting.
// - Dual-port, enabled bias output shows transmit or receive state.
// - Bias output tri-stated while bit 14 is 0, its reset value.
// - Bit 14 at 1 drives bias output from mode, polarity and activity.
// - Polarity bit 13 acts only in dual-port mode with output enabled.
// - Bit 13 at 1 inverts dual-port bias sense; reset value 0.
module rfpc_top
(
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Register port from the serial host interface
  input wire [5:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  // Radio activity
  input wire tx_active,
  input wire rx_active,
  // RF path controls
  output reg shared_pad_rx_sw_q,
  output reg shared_pad_amp_en_q,
  output reg amp_out_amp_en_q,
  output reg shared_pad_bidir_q,
  // Switched bias pin
  output wire switched_bias_out,
  output wire switched_bias_out_oe
);
  reg [15:0] ctrl_q;
  reg [15:0] rdata_d;
  reg [5:0] path_sel;
  reg rx_sw_d;
  reg shared_amp_d;
  reg out_amp_d;
  reg bidir_d;
  wire addr_hit;
  wire wr_hit;
  wire rd_hit;
  wire tx_req;
  wire rx_req;
  wire port_config_select;
  wire bias_out_invert;
  wire bias_out_enable;

  // One-hot codes for how the RF pads are in use
  localparam [5:0] PATH_DUAL_IDLE = 6'h01;
  localparam [5:0] PATH_DUAL_RX = 6'h02;
  localparam [5:0] PATH_DUAL_TX = 6'h04;
  localparam [5:0] PATH_SINGLE_IDLE = 6'h08;
  localparam [5:0] PATH_SINGLE_RX = 6'h10;
  localparam [5:0] PATH_SINGLE_TX = 6'h20;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign addr_hit = (reg_addr == `RFPC_SEC_CTRL_ADDR);
  assign wr_hit = reg_wr & addr_hit;
  assign rd_hit = reg_rd & addr_hit;

  // ----------------------------------------
  // Secondary control register
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (srst)
      ctrl_q <= `RFPC_SEC_CTRL_RESET;
    else if (wr_hit)
      ctrl_q <= reg_wdata;
  end

  assign port_config_select = ctrl_q[`RFPC_PORT_SEL_BIT];
  assign bias_out_invert = ctrl_q[`RFPC_BIAS_INV_BIT];
  assign bias_out_enable = ctrl_q[`RFPC_BIAS_EN_BIT];

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Unmapped reads return zero; the last value holds between reads
  always @*
  begin
    rdata_d = reg_rdata_q;
    if (rd_hit)
      rdata_d = ctrl_q;
    else if (reg_rd)
      rdata_d = 16'h0000;
  end

  always @(posedge mclk)
  begin
    if (srst)
      reg_rdata_q <= 16'h0000;
    else
      reg_rdata_q <= rdata_d;
  end

  // ----------------------------------------
  // Radio activity
  // ----------------------------------------
  // Transmit wins when both activity flags are up
  assign tx_req = tx_active;
  assign rx_req = rx_active & ~tx_active;

  // ----------------------------------------
  // RF path selection
  // ----------------------------------------
  always @*
  begin
    path_sel = PATH_DUAL_IDLE;
    if (port_config_select)
    begin
      if (tx_req)
        path_sel = PATH_SINGLE_TX;
      else if (rx_req)
        path_sel = PATH_SINGLE_RX;
      else
        path_sel = PATH_SINGLE_IDLE;
    end
    else
    begin
      if (tx_req)
        path_sel = PATH_DUAL_TX;
      else if (rx_req)
        path_sel = PATH_DUAL_RX;
      else
        path_sel = PATH_DUAL_IDLE;
    end
  end

  // Pad use for each path; unknown codes fall back to dual-port receive
  always @*
  begin
    rx_sw_d = 1'b1;
    shared_amp_d = 1'b0;
    out_amp_d = 1'b0;
    bidir_d = 1'b0;
    case (path_sel)
      PATH_SINGLE_TX:
      begin
        bidir_d = 1'b1;
        rx_sw_d = 1'b0;
        shared_amp_d = 1'b1;
        out_amp_d = 1'b0;
      end
      PATH_SINGLE_RX:
      begin
        bidir_d = 1'b1;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b0;
      end
      PATH_SINGLE_IDLE:
      begin
        bidir_d = 1'b1;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b0;
      end
      PATH_DUAL_TX:
      begin
        bidir_d = 1'b0;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b1;
      end
      PATH_DUAL_RX:
      begin
        bidir_d = 1'b0;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b0;
      end
      PATH_DUAL_IDLE:
      begin
        bidir_d = 1'b0;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b0;
      end
      default:
      begin
        bidir_d = 1'b0;
        rx_sw_d = 1'b1;
        shared_amp_d = 1'b0;
        out_amp_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // RF path control registers
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (srst)
    begin
      shared_pad_rx_sw_q <= 1'b1;
      shared_pad_amp_en_q <= 1'b0;
      amp_out_amp_en_q <= 1'b0;
      shared_pad_bidir_q <= 1'b0;
    end
    else
    begin
      shared_pad_rx_sw_q <= rx_sw_d;
      shared_pad_amp_en_q <= shared_amp_d;
      amp_out_amp_en_q <= out_amp_d;
      shared_pad_bidir_q <= bidir_d;
    end
  end

  // ----------------------------------------
  // Switched bias output
  // ----------------------------------------
  rfpc_bias_drive u_bias
  (
    .mclk(mclk),
    .srst(srst),
    .bias_out_enable(bias_out_enable),
    .bias_out_invert(bias_out_invert),
    .port_config_select(port_config_select),
    .tx_active(tx_active),
    .rx_active(rx_active),
    .bias_out_q(switched_bias_out),
    .bias_out_oe_q(switched_bias_out_oe)
  );
endmodule

// ### rfpc_regs.vh
// Register offsets, field positions and reset values for the RF port and bias control
`ifndef RFPC_REGS_VH
`define RFPC_REGS_VH
`define RFPC_SEC_CTRL_ADDR 6'h07
`define RFPC_SEC_CTRL_RESET 16'h0000
`define RFPC_PORT_SEL_BIT 12
`define RFPC_BIAS_INV_BIT 13
`define RFPC_BIAS_EN_BIT 14
`endif

// ### rfpc_bias_drive.v
// Switched bias output level and enable logic
`timescale 1ns/1ps
module rfpc_bias_drive
(
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Control
  input wire bias_out_enable,
  input wire bias_out_invert,
  input wire port_config_select,
  input wire tx_active,
  input wire rx_active,
  // Pin
  output reg bias_out_q,
  output reg bias_out_oe_q
);
  reg level_d;

  always @*
  begin
    level_d = 1'b0;
    if (port_config_select)
      level_d = tx_active;
    else if (tx_active || rx_active)
      level_d = tx_active ^ bias_out_invert;
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      bias_out_q <= 1'b0;
      bias_out_oe_q <= 1'b0;
    end
    else
    begin
      bias_out_oe_q <= bias_out_enable;
      bias_out_q <= bias_out_enable & level_d;
    end
  end
endmodule

// ### rfpc_checker.sv
// Assertion checker for the RF port and bias control
`timescale 1ns/1ps
module rfpc_checker (input wire mclk, input wire srst, input wire [5:0] reg_addr,
  input wire [15:0] reg_wdata, input wire reg_wr, input wire reg_rd,
  input wire [15:0] reg_rdata_q, input wire tx_active, input wire rx_active,
  input wire shared_pad_rx_sw_q, input wire shared_pad_amp_en_q, input wire amp_out_amp_en_q,
  input wire shared_pad_bidir_q, input wire switched_bias_out, input wire switched_bias_out_oe);
  logic [15:0] c_q, p_q;
  logic t_q, r_q;
  // Shadow of the control word and of what the outputs were computed from
  always @(posedge mclk)
  begin
    c_q <= srst ? 16'h0000 : (reg_wr && reg_addr == 6'h07) ? reg_wdata : c_q;
    p_q <= c_q;
    t_q <= tx_active;
    r_q <= rx_active;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_en_wr;
    reg_wr && reg_addr == 6'h07 && reg_wdata[14] ##1 !reg_wr;
  endsequence
  AST_BIAS_OFF: assert property (!p_q[14] |-> !switched_bias_out_oe)
    else $error("bias pin driven while disabled");
  AST_BIAS_ON: assert property (s_en_wr |=> switched_bias_out_oe)
    else $error("bias pin not driven after enable");
  AST_SP_BIAS: assert property (p_q[14] && p_q[12] |-> switched_bias_out == t_q)
    else $error("single-port bias level wrong");
  AST_DP_TX: assert property (p_q[14] && !p_q[12] && t_q |-> switched_bias_out != p_q[13])
    else $error("dual-port transmit bias wrong");
  AST_DP_RX: assert property (p_q[14] && !p_q[12] && !t_q && r_q |->
    switched_bias_out == p_q[13])
    else $error("dual-port receive bias wrong");
  AST_RD: assert property (reg_rd && reg_addr == 6'h07 |=> reg_rdata_q == $past(c_q))
    else $error("control read-back wrong");
  AST_SP_PATH: assert property (p_q[12] |-> shared_pad_bidir_q &&
    shared_pad_rx_sw_q != t_q && shared_pad_amp_en_q == t_q)
    else $error("single-port path wrong");
  AST_DP_PATH: assert property (!p_q[12] |-> !shared_pad_bidir_q &&
    !shared_pad_amp_en_q && amp_out_amp_en_q == t_q && (t_q || shared_pad_rx_sw_q))
    else $error("dual-port path wrong");
endmodule
bind rfpc_top rfpc_checker u_rfpc_checker (.*);

// ### rfpc_ext_switch.sv
// Model of the external balun tap or antenna switch on the bias pin
`timescale 1ns/1ps
module rfpc_ext_switch (input wire mclk, input wire switched_bias_out,
  input wire switched_bias_out_oe, output logic ext_pin);
  logic last_q = 1'b0;
  always @(posedge mclk) if (switched_bias_out_oe) last_q <= switched_bias_out;
  // Released pin floats: show the opposite of the last driven level
  assign ext_pin = switched_bias_out_oe ? switched_bias_out : !last_q;
endmodule

// ### rf_port_and_bias_control_bench.sv
// Self-checking bench for the RF port and bias control
`timescale 1ns/1ps
module rf_port_and_bias_control_bench;
  logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, tx_active = 0, rx_active = 0, ck = 0, rv = 0;
  logic [5:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata_q, v, e, w;
  logic shared_pad_rx_sw_q, shared_pad_amp_en_q, amp_out_amp_en_q, shared_pad_bidir_q;
  logic switched_bias_out, switched_bias_out_oe, ext_pin;
  logic [15:0] q[$];
  int fail_count = 0, check_count = 0, s;
  rfpc_top u_rfpc_top (.*);
  rfpc_ext_switch u_rfpc_ext_switch (.*);
  always #5 mclk = ~mclk;
  task cyc(input logic [5:0] a, input logic wr, input logic [15:0] d);
    reg_addr <= a;
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_wdata <= d;
    @(posedge mclk) {reg_wr, reg_rd} <= 2'b00;
  endtask
  function automatic logic [15:0] pins(input logic [15:0] c, input logic t, input logic r);
    logic b;
    b = c[12] ? t : (t ? !c[13] : (r & c[13]));
    return {10'h000, c[12], c[12] & t, !c[12] & t, !(c[12] & t), c[14], c[14] & b};
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    rv <= reg_rd;
    if (rv || ck)
    begin
      v = rv ? reg_rdata_q : {10'h000, shared_pad_bidir_q, shared_pad_amp_en_q, amp_out_amp_en_q,
        shared_pad_rx_sw_q, switched_bias_out_oe, switched_bias_out_oe & ext_pin};
      e = q.pop_front();
      check_count++;
      if (e !== v)
      begin
        fail_count++;
        $display("[FAIL] %s expected %h seen %h", rv ? "rdata" : "pins", e, v);
      end
    end
  end
  initial
  begin
    s = $urandom(88695);
    repeat (16) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    cyc(6'h08, 1, 16'hffff);
    @(posedge mclk);
    q.push_back(16'h0000);
    cyc(6'h07, 0, 0);
    @(posedge mclk);
    q.push_back(16'h0000);
    cyc(6'h08, 0, 0);
    for (int i = 0; i < 80; i++)
    begin
      w = 16'($urandom);
      @(posedge mclk);
      cyc(6'h07, 1, w);
      {tx_active, rx_active} <= 2'($urandom);
      @(posedge mclk);
      q.push_back(pins(w, tx_active, rx_active));
      ck <= 1;
      @(posedge mclk) ck <= 0;
      q.push_back(w);
      cyc(6'h07, 0, 0);
    end
    @(posedge mclk);
    q.push_back(16'h0000);
    cyc(6'h08, 0, 0);
    repeat (3) @(posedge mclk);
    close_out;
  end
  initial
  begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule
